/* File: rtl/mcg_pkg.sv */
// mode strap and clock generator constants, types and timing counts
// assumes a single 10 MHz system clock and a synchronous power-on reset
package mcg_pkg;

  // ==========================================================
  // timing
  localparam int unsigned MCG_CLK_PERIOD_NS = 100;
  // oscillator stabilisation wait, least time, rounds up
  localparam int unsigned MCG_STAB_TIME_NS  = 10000000;
  localparam int unsigned MCG_STAB_CYC_DFLT =
    (MCG_STAB_TIME_NS + MCG_CLK_PERIOD_NS - 1) / MCG_CLK_PERIOD_NS;
  localparam int unsigned MCG_STAB_W        = 20;
  // no external clock change for this long means halted, rounds down
  localparam int unsigned MCG_HALT_TIME_NS  = 2000;
  localparam int unsigned MCG_HALT_CYC      = MCG_HALT_TIME_NS / MCG_CLK_PERIOD_NS;
  localparam int unsigned MCG_HALT_W        = 8;

  // ==========================================================
  // widths
  localparam int unsigned MCG_PRESC_W = 13;  // taps phi/2 .. phi/8192
  localparam int unsigned MCG_TMR_N   = 6;   // high-current timer pins
  localparam int unsigned MCG_STRAP_W = 7;   // large pkg, flash var, wp, mode[3:0]

  // ==========================================================
  // strap field positions and codes
  localparam int unsigned MCG_SP_LARGE = 6;
  localparam int unsigned MCG_SP_FLASH = 5;
  localparam int unsigned MCG_SP_WP    = 4;
  localparam logic [1:0]  MCG_LO_MCU0  = 2'h0;
  localparam logic [1:0]  MCG_LO_MCU1  = 2'h1;
  localparam logic [1:0]  MCG_LO_MCU2  = 2'h2;
  localparam logic [3:0]  MCG_MD_PROM  = 4'hF;
  localparam logic [3:0]  MCG_MD_FPGM  = 4'hD;
  localparam logic [1:0]  MCG_CK_X1    = 2'h0;
  localparam logic [1:0]  MCG_CK_X2    = 2'h1;
  localparam logic [1:0]  MCG_CK_X4    = 2'h2;
  localparam logic [2:0]  MCG_MULT_X1   = 3'h1;
  localparam logic [2:0]  MCG_MULT_X2   = 3'h2;
  localparam logic [2:0]  MCG_MULT_X4   = 3'h4;
  localparam logic [2:0]  MCG_MULT_NONE = 3'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MCG_W8    = 2'h0,
    MCG_W16   = 2'h1,
    MCG_W32   = 2'h2,
    MCG_WNONE = 2'h3
  } mcg_width_t;

  typedef enum logic [2:0] {
    MCG_OP_MCU0   = 3'h0,
    MCG_OP_MCU1   = 3'h1,
    MCG_OP_MCU2   = 3'h2,
    MCG_OP_SINGLE = 3'h3,
    MCG_OP_PROM   = 3'h4,
    MCG_OP_FLASH  = 3'h5
  } mcg_op_t;

endpackage : mcg_pkg

/* File: rtl/mcg_presc_if.sv */
// prescaler tap bundle between the clock block and its prescaler
// assumes both ends sit on sys_clk
`timescale 1ns/1ps
interface mcg_presc_if;
  import mcg_pkg::*;
  logic [MCG_PRESC_W-1:0] tick;  // bit k pulses once per 2^(k+1) cycles
  modport src (output tick);
  modport snk (input  tick);
endinterface : mcg_presc_if

/* File: rtl/mcg_prescaler.sv */
// free-running prescaler: one-cycle enables at phi/2 .. phi/8192
// assumes sys_clk is phi and a synchronous active-high reset
`timescale 1ns/1ps
module mcg_prescaler
  import mcg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // taps
  mcg_presc_if.src  presc
);

  typedef struct packed {
    logic [MCG_PRESC_W-1:0] cnt;
    logic [MCG_PRESC_W-1:0] tick;
  } mcg_presc_st_t;

  mcg_presc_st_t s_r;
  mcg_presc_st_t s_nxt;

  // ==========================================================
  // tap decode
  function automatic logic f_tap(input logic [MCG_PRESC_W-1:0] c, input int k);
    logic [MCG_PRESC_W-1:0] m;
    m = MCG_PRESC_W'((32'h1 << (k + 1)) - 32'h1);
    return (c & m) == m;
  endfunction : f_tap

  // ==========================================================
  // counter and registered taps; all taps share one counter so they align
  always_comb begin
    s_nxt     = s_r;
    s_nxt.cnt = s_r.cnt + MCG_PRESC_W'(1);
    for (int k = 0; k < int'(MCG_PRESC_W); k++) begin
      s_nxt.tick[k] = f_tap(s_r.cnt, k);
    end
    if (sys_rst_i) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_r <= s_nxt;
  end

  assign presc.tick = s_r.tick;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_presc_half: assert property (presc.tick[0] |=> !presc.tick[0] ##1 presc.tick[0])
    else $error("phi/2 tap does not alternate");
  chk_presc_nest: assert property (presc.tick[MCG_PRESC_W-1] |-> (&presc.tick))
    else $error("slowest tap not aligned with faster taps");
  cov_presc_slow: cover property (presc.tick[MCG_PRESC_W-1]);

endmodule : mcg_prescaler

/* File: rtl/mcg_mode_clk.sv */
// mode strap decode, clock mode, oscillator halt detect and prescaler
// assumes straps and external clock arrive asynchronously; sys_clk is phi
`timescale 1ns/1ps
module mcg_mode_clk
  import mcg_pkg::*;
#(
  parameter int unsigned STAB_CYC = MCG_STAB_CYC_DFLT
)(
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   sys_rst_i,
  // board straps
  input  wire logic [3:0]             mode_strap_pins_i,
  input  wire logic                   flash_write_protect_pin_i,
  input  wire logic                   pkg_large_i,
  input  wire logic                   flash_variant_i,
  // clock source and power state
  input  wire logic                   external_clock_input_i,
  input  wire logic                   standby_i,
  // bus controller width for cs0 in mode 2 and flash programming mode
  input  wire logic [1:0]             bus_control_register_two_i,
  // timer pins from the pin function controller
  input  wire logic [MCG_TMR_N-1:0]   tmr_out_i,
  input  wire logic [MCG_TMR_N-1:0]   tmr_oe_i,
  // decoded mode
  output logic [2:0]                  op_mode_o,
  output logic                        rom_enable_o,
  output logic                        cs0_external_o,
  output logic [1:0]                  cs0_width_o,
  output logic [2:0]                  pll_mult_o,
  // clock status
  output logic                        osc_stable_o,
  output logic                        clk_halt_o,
  output logic                        op_undefined_o,
  output logic [MCG_PRESC_W-1:0]      presc_tick_o,
  // timer pins to the pads
  output logic [MCG_TMR_N-1:0]        tmr_out_o,
  output logic [MCG_TMR_N-1:0]        tmr_oe_o
);

  localparam logic [MCG_STAB_W-1:0] STAB_LIM = MCG_STAB_W'(STAB_CYC - 1);
  localparam logic [MCG_HALT_W-1:0] HALT_LIM = MCG_HALT_W'(MCG_HALT_CYC);

  typedef struct packed {
    logic [MCG_STRAP_W-1:0] sp_s1;
    logic [MCG_STRAP_W-1:0] sp_s2;
    logic [MCG_STRAP_W-1:0] sp_s3;
    logic                   ex_s1;
    logic                   ex_s2;
    logic                   ex_s3;
    logic                   ex_acc;
    mcg_op_t                op;
    logic [2:0]             mult;
    logic                   rom_en;
    logic                   cs0_ext;
    mcg_width_t             cs0_fix;
    mcg_width_t             cs0_w;
    logic [MCG_HALT_W-1:0]  halt_cnt;
    logic                   halted;
    logic                   fault;
    logic [MCG_STAB_W-1:0]  stab_cnt;
    logic                   stable;
    logic                   stby_d;
    logic [MCG_TMR_N-1:0]   t_out;
    logic [MCG_TMR_N-1:0]   t_oe;
  } mcg_st_t;

  mcg_st_t s_r;
  mcg_st_t s_nxt;
  logic    ex_chg;

  // ==========================================================
  // decode helpers
  function automatic logic f_agree(input logic [MCG_STRAP_W-1:0] a,
                                   input logic [MCG_STRAP_W-1:0] b);
    return a == b;
  endfunction : f_agree

  function automatic mcg_op_t f_op(input logic [MCG_STRAP_W-1:0] sp);
    logic [3:0] md;
    md = sp[3:0];
    if (!sp[MCG_SP_WP]) begin
      return MCG_OP_FLASH;                       // on-board programming strap
    end
    if (md == MCG_MD_PROM) begin
      return MCG_OP_PROM;
    end
    if (sp[MCG_SP_FLASH] && md == MCG_MD_FPGM) begin
      return MCG_OP_FLASH;
    end
    case (md[1:0])
      MCG_LO_MCU0: return MCG_OP_MCU0;
      MCG_LO_MCU1: return MCG_OP_MCU1;
      MCG_LO_MCU2: return MCG_OP_MCU2;
      default:     return MCG_OP_SINGLE;
    endcase
  endfunction : f_op

  function automatic logic [2:0] f_mult(input mcg_op_t op, input logic [1:0] ck);
    if (op == MCG_OP_PROM || op == MCG_OP_FLASH) begin
      return MCG_MULT_NONE;
    end
    case (ck)
      MCG_CK_X1: return MCG_MULT_X1;
      MCG_CK_X2: return MCG_MULT_X2;
      MCG_CK_X4: return MCG_MULT_X4;
      default:   return MCG_MULT_NONE;           // reserved code
    endcase
  endfunction : f_mult

  // ==========================================================
  // prescaler
  mcg_presc_if presc ();

  mcg_prescaler u_presc (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .presc     (presc.src)
  );

  assign presc_tick_o = presc.tick;

  // ==========================================================
  // next state
  // only stage 2 and 3 of each synchroniser are compared
  assign ex_chg = (s_r.ex_s2 == s_r.ex_s3) && (s_r.ex_s3 != s_r.ex_acc);

  always_comb begin
    s_nxt = s_r;
    // synchronisers always run, also in reset, so straps settle for the latch
    s_nxt.sp_s1 = {pkg_large_i, flash_variant_i, flash_write_protect_pin_i,
                   mode_strap_pins_i};
    s_nxt.sp_s2 = s_r.sp_s1;
    s_nxt.sp_s3 = s_r.sp_s2;
    s_nxt.ex_s1 = external_clock_input_i;
    s_nxt.ex_s2 = s_r.ex_s1;
    s_nxt.ex_s3 = s_r.ex_s2;
    if (ex_chg) begin
      s_nxt.ex_acc = s_r.ex_s3;
    end
    s_nxt.stby_d = standby_i;

    // halt detector: sys_clk acts as the timebase for the edge timeout
    if (ex_chg || standby_i) begin
      s_nxt.halt_cnt = '0;
    end else if (s_r.halt_cnt != HALT_LIM) begin
      s_nxt.halt_cnt = s_r.halt_cnt + MCG_HALT_W'(1);
    end
    s_nxt.halted = (s_nxt.halt_cnt == HALT_LIM);
    // a stop outside standby is never recovered from without reset
    if (s_r.halted && !standby_i) begin
      s_nxt.fault = 1'b1;
    end

    // stabilisation wait after standby
    if (standby_i || (s_r.stby_d && !standby_i)) begin
      s_nxt.stable   = 1'b0;
      s_nxt.stab_cnt = '0;
    end else if (!s_r.stable) begin
      if (s_r.stab_cnt == STAB_LIM) begin
        s_nxt.stable = 1'b1;
      end else begin
        s_nxt.stab_cnt = s_r.stab_cnt + MCG_STAB_W'(1);
      end
    end

    // cs0 width: fixed by straps, or by the bus controller in mode 2 and flash programming mode
    if (s_r.op == MCG_OP_MCU2 || s_r.op == MCG_OP_FLASH) begin
      s_nxt.cs0_w = mcg_width_t'(bus_control_register_two_i);
    end else begin
      s_nxt.cs0_w = s_r.cs0_fix;
    end

    // timer pad override beats the pin function controller
    s_nxt.t_out = tmr_out_i;
    if (s_r.halted || s_r.fault || standby_i) begin
      s_nxt.t_oe = '0;
    end else begin
      s_nxt.t_oe = tmr_oe_i;
    end

    // power-on reset: clear control, relatch straps once they settle
    if (sys_rst_i) begin
      s_nxt.halt_cnt = '0;
      s_nxt.halted   = 1'b0;
      s_nxt.fault    = 1'b0;
      s_nxt.stab_cnt = '0;
      s_nxt.stable   = 1'b0;
      s_nxt.t_oe     = '0;
      s_nxt.t_out    = '0;
      s_nxt.ex_acc   = 1'b0;
      s_nxt.cs0_w    = MCG_WNONE;
      // any strap, bit1 included, may move while reset is held
      if (f_agree(s_r.sp_s2, s_r.sp_s3)) begin
        s_nxt.op      = f_op(s_r.sp_s3);
        s_nxt.mult    = f_mult(f_op(s_r.sp_s3), s_r.sp_s3[3:2]);
        s_nxt.rom_en  = !(f_op(s_r.sp_s3) inside {MCG_OP_MCU0, MCG_OP_MCU1});
        s_nxt.cs0_ext = f_op(s_r.sp_s3) inside
                        {MCG_OP_MCU0, MCG_OP_MCU1, MCG_OP_MCU2, MCG_OP_FLASH};
        case (f_op(s_r.sp_s3))
          MCG_OP_MCU0: s_nxt.cs0_fix = s_r.sp_s3[MCG_SP_LARGE] ? MCG_W16 : MCG_W8;
          MCG_OP_MCU1: s_nxt.cs0_fix = s_r.sp_s3[MCG_SP_LARGE] ? MCG_W32 : MCG_W16;
          default:     s_nxt.cs0_fix = MCG_WNONE;
        endcase
      end
    end
  end

  // the straps are never looked at again after reset
  always_ff @(posedge sys_clk_i) begin
    s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  assign op_mode_o      = s_r.op;
  assign rom_enable_o   = s_r.rom_en;
  assign cs0_external_o = s_r.cs0_ext;
  assign cs0_width_o    = s_r.cs0_w;
  assign pll_mult_o     = s_r.mult;
  assign osc_stable_o   = s_r.stable;
  assign clk_halt_o     = s_r.halted;
  assign op_undefined_o = s_r.fault;
  assign tmr_out_o      = s_r.t_out;
  assign tmr_oe_o       = s_r.t_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // synchronised straps match the latch only on the first edge after release;
  // the board may move them later, so strap-based checks look at that edge only
  chk_mode0_width: assert property ($past(sys_rst_i) && s_r.op == MCG_OP_MCU0 |->
    !rom_enable_o && cs0_external_o &&
    s_r.cs0_fix == (s_r.sp_s3[MCG_SP_LARGE] ? MCG_W16 : MCG_W8))
    else $error("mode 0 decode wrong");
  chk_mode1_width: assert property ($past(sys_rst_i) && s_r.op == MCG_OP_MCU1 |->
    !rom_enable_o && cs0_external_o &&
    s_r.cs0_fix == (s_r.sp_s3[MCG_SP_LARGE] ? MCG_W32 : MCG_W16))
    else $error("mode 1 decode wrong");
  chk_cs0_fixed: assert property (s_r.op inside {MCG_OP_MCU0, MCG_OP_MCU1, MCG_OP_SINGLE,
    MCG_OP_PROM} |=> cs0_width_o == $past(s_r.cs0_fix))
    else $error("fixed cs0 width not driven");
  chk_mode2_bus: assert property (s_r.op == MCG_OP_MCU2 |=>
    rom_enable_o && cs0_width_o == $past(bus_control_register_two_i))
    else $error("mode 2 width not from bus controller");
  chk_single_chip: assert property (s_r.op == MCG_OP_SINGLE |->
    rom_enable_o && !cs0_external_o && cs0_width_o == MCG_WNONE)
    else $error("single chip mode exposes external space");
  chk_prog_mode: assert property ($fell(sys_rst_i) && s_r.sp_s3 [4:0] == 5'h1F |->
    op_mode_o == MCG_OP_PROM && pll_mult_o == MCG_MULT_NONE)
    else $error("programming strap not decoded");
  chk_pll_mult: assert property ($past(sys_rst_i) &&
    s_r.op inside {MCG_OP_MCU0, MCG_OP_MCU1, MCG_OP_MCU2, MCG_OP_SINGLE} |->
    pll_mult_o == (s_r.sp_s3[3:2] == MCG_CK_X1 ? MCG_MULT_X1 :
                   s_r.sp_s3[3:2] == MCG_CK_X2 ? MCG_MULT_X2 :
                   s_r.sp_s3[3:2] == MCG_CK_X4 ? MCG_MULT_X4 : MCG_MULT_NONE))
    else $error("clock multiplier wrong");
  chk_stab_count: assert property ($rose(osc_stable_o) |-> $past(s_r.stab_cnt) == STAB_LIM)
    else $error("stable raised before wait elapsed");
  chk_stab_exit: assert property ($fell(standby_i) |-> !osc_stable_o ##1 !osc_stable_o)
    else $error("stable kept across standby exit");
  chk_halt_hiz: assert property (clk_halt_o && !standby_i |=> tmr_oe_o == '0)
    else $error("timer pins driven while clock halted");
  chk_stby_hiz: assert property (standby_i |=> tmr_oe_o == '0)
    else $error("timer pins driven in standby");
  chk_fault_sticky: assert property (op_undefined_o |=> op_undefined_o && tmr_oe_o == '0)
    else $error("undefined state left without reset");
  chk_fault_set: assert property (clk_halt_o && !standby_i |=> op_undefined_o)
    else $error("halt outside standby not flagged undefined");
  chk_pins_follow: assert property (!clk_halt_o && !op_undefined_o && !standby_i |=>
    tmr_oe_o == $past(tmr_oe_i) && tmr_out_o == $past(tmr_out_i))
    else $error("timer pins not passed through");
  chk_halt_clear: assert property (ex_chg |=> !clk_halt_o)
    else $error("halt kept after a clock edge");
  chk_halt_timeout: assert property (s_r.halt_cnt == HALT_LIM - MCG_HALT_W'(1) &&
    !ex_chg && !standby_i |=> clk_halt_o)
    else $error("halt not flagged at timeout");
  chk_mode_hold: assert property (!$past(sys_rst_i) |-> $stable(op_mode_o) && $stable(pll_mult_o))
    else $error("latched mode changed outside reset");

  cov_mode0:  cover property ($fell(sys_rst_i) && op_mode_o == MCG_OP_MCU0);
  cov_prom:   cover property ($fell(sys_rst_i) && op_mode_o == MCG_OP_PROM);
  cov_halt:   cover property ($rose(clk_halt_o) && !standby_i);
  cov_stable: cover property ($rose(osc_stable_o));

endmodule : mcg_mode_clk

/* File: test/mcg_board_model.sv */
// board model: mode strap levels and the external clock source
// assumes the bench commands strap values, run, speed and standby
`timescale 1ns/1ps
module mcg_board_model (
  // commands from the bench
  input  wire logic       sys_rst_i,
  input  wire logic [6:0] strap_i,
  input  wire logic       bend_i,
  input  wire logic       run_i,
  input  wire logic       slow_i,
  input  wire logic       standby_i,
  // pins toward the device
  output logic [6:0]      strap_o,
  output logic            ext_clk_o
);
  // ==========================================================
  // straps
  // levels move only in reset; bend_i lets a scenario break that on purpose
  always @(*) begin
    if (sys_rst_i || bend_i) begin
      strap_o = strap_i;
    end
  end

  // ==========================================================
  // external clock
  // limitation: 2.5 MHz at most, the 10 MHz sampler aliases anything faster
  initial begin
    ext_clk_o = 1'b1;
    #37;
    forever begin
      if (standby_i) begin
        ext_clk_o = 1'b1;
        #50;
      end else if (run_i) begin
        // rate scaled down against the 10 MHz sampler
        #(slow_i ? 1000 : 200);
        ext_clk_o = ~ext_clk_o;
      end else begin
        #50; // fault: clock frozen at its last level
      end
    end
  end
endmodule : mcg_board_model

/* File: test/tb.sv */
// testbench for the mode strap decode and clock generator block
// assumes the board model above and a shortened stabilisation count
`timescale 1ns/1ps
module tb;
  import mcg_pkg::*;
  localparam int unsigned STAB = 8;

  logic                   sys_clk_i;
  logic                   sys_rst_i;
  logic [6:0]             strap;
  logic [6:0]             straps;
  logic [6:0]             pins;
  logic                   ext_clk;
  logic                   bend;
  logic                   run;
  logic                   slow;
  logic                   standby;
  logic [1:0]             bus;
  logic [MCG_TMR_N-1:0]   t_out;
  logic [MCG_TMR_N-1:0]   t_oe;
  logic [2:0]             op_mode_o;
  logic                   rom_enable_o;
  logic                   cs0_external_o;
  logic [1:0]             cs0_width_o;
  logic [2:0]             pll_mult_o;
  logic                   osc_stable_o;
  logic                   clk_halt_o;
  logic                   op_undefined_o;
  logic [MCG_PRESC_W-1:0] presc_tick_o;
  logic [MCG_TMR_N-1:0]   tmr_out_o;
  logic [MCG_TMR_N-1:0]   tmr_oe_o;
  int                     bad_count;
  int                     comparisons;
  int                     seed;
  int                     n;
  int                     k;
  int                     cnt [13];

  // ==========================================================
  // device and board
  mcg_board_model board_u (.sys_rst_i(sys_rst_i), .strap_i(strap), .bend_i(bend),
    .run_i(run), .slow_i(slow), .standby_i(standby), .strap_o(pins), .ext_clk_o(ext_clk));

  mcg_mode_clk #(.STAB_CYC(STAB)) dut_u (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .mode_strap_pins_i(pins[3:0]), .flash_write_protect_pin_i(pins[4]),
    .pkg_large_i(pins[6]), .flash_variant_i(pins[5]),
    .external_clock_input_i(ext_clk), .standby_i(standby),
    .bus_control_register_two_i(bus), .tmr_out_i(t_out), .tmr_oe_i(t_oe),
    .op_mode_o(op_mode_o), .rom_enable_o(rom_enable_o), .cs0_external_o(cs0_external_o),
    .cs0_width_o(cs0_width_o), .pll_mult_o(pll_mult_o), .osc_stable_o(osc_stable_o),
    .clk_halt_o(clk_halt_o), .op_undefined_o(op_undefined_o),
    .presc_tick_o(presc_tick_o), .tmr_out_o(tmr_out_o), .tmr_oe_o(tmr_oe_o));

  // ==========================================================
  // expectations and checks
  // decode as {op, rom, external, width, multiplier}
  function automatic logic [9:0] exp_mode(input logic [6:0] s, input logic [1:0] bc);
    logic [2:0] op;
    logic [2:0] mult;
    logic [1:0] w;
    mult = (s[3:2] == 2'h0) ? 3'h1 : (s[3:2] == 2'h1) ? 3'h2 : (s[3:2] == 2'h2) ? 3'h4 : 3'h0;
    if (!s[4]) op = 3'h5;
    else if (s[3:0] == 4'hF) op = 3'h4;
    else if (s[5] && s[3:0] == 4'hD) op = 3'h5;
    else op = {1'b0, s[1:0]};
    // programming modes run with no multiplier
    if (op > 3'h3) mult = 3'h0;
    case (op)
      3'h0: w = s[6] ? 2'h1 : 2'h0;
      3'h1: w = s[6] ? 2'h2 : 2'h1;
      3'h2, 3'h5: w = bc;
      default: w = 2'h3;
    endcase
    return {op, op > 3'h1, (op < 3'h3) || (op == 3'h5), w, mult};
  endfunction : exp_mode

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check_vec

  task automatic check_mode(input logic [9:0] exp);
    check_vec({6'h00, op_mode_o, rom_enable_o, cs0_external_o, cs0_width_o, pll_mult_o},
              {6'h00, exp}, "mode decode");
  endtask : check_mode

  // straps a, then b while still in reset, then release
  task automatic do_reset(input logic [6:0] a, input logic [6:0] b);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    strap     = a;
    repeat (3) @(negedge sys_clk_i);
    strap = b;
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
  endtask : do_reset

  // edges from now until the stable flag shows, bounded
  task automatic wait_stable(input int exp_n);
    n = 0;
    while (osc_stable_o !== 1'b1 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    check_vec(16'(n), 16'(exp_n), "stabilisation edges");
  endtask : wait_stable

  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // clock and watchdog
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // about 17k cycles expected; three times that is a hang
  initial begin
    #5000000;
    bad_count++;
    complete_run();
  end

  // ==========================================================
  // scenarios
  initial begin
    seed = 32'h0FE1745A;
    bad_count = 0;
    comparisons = 0;
    sys_rst_i = 1'b1;
    strap = 7'h10;
    {bend, slow, standby, run} = 4'h1;
    bus = 2'h0;
    t_out = '0;
    t_oe = '0;
    repeat (4) @(negedge sys_clk_i);
    // every mode code with random package and flash straps, then random and corner straps
    for (k = 0; k < 24; k++) begin
      straps = 7'($random(seed));
      if (k < 16) straps[4:0] = {1'b1, k[3:0]};
      if (k == 16) straps = 7'h3D;
      if (k == 17) straps[4] = 1'b0;
      bus = 2'($random(seed));
      do_reset(straps ^ 7'h02, straps);
      @(negedge sys_clk_i);
      check_mode(exp_mode(straps, bus));
      bend = 1'b1;
      strap = 7'($random(seed));
      repeat (5) @(negedge sys_clk_i);
      bend = 1'b0;
      check_mode(exp_mode(straps, bus));
    end
    do_reset(7'h10, 7'h10);
    wait_stable(STAB);
    // every tap over a whole number of its periods
    for (k = 0; k < 13; k++) cnt[k] = 0;
    repeat (16384) begin
      @(negedge sys_clk_i);
      for (k = 0; k < 13; k++) if (presc_tick_o[k] === 1'b1) cnt[k]++;
    end
    for (k = 0; k < 13; k++) check_vec(16'(cnt[k]), 16'(1 << (13 - k)), "tap pulses");
    // pins pass through with a slow but live clock
    slow = 1'b1;
    repeat (20) begin
      t_out = 6'($random(seed));
      t_oe  = 6'($random(seed));
      @(negedge sys_clk_i);
      check_vec({4'h0, tmr_out_o, tmr_oe_o}, {4'h0, t_out, t_oe}, "timer pins");
    end
    check_vec({15'h0000, clk_halt_o}, 16'h0000, "halt on slow clock");
    slow = 1'b0;
    // standby: pins hi-z, no fault, then normal after the wait
    standby = 1'b1;
    @(negedge sys_clk_i);
    check_vec({10'h000, tmr_oe_o}, 16'h0000, "standby enables");
    repeat (40) @(negedge sys_clk_i);
    check_vec({8'h00, clk_halt_o, op_undefined_o, tmr_oe_o}, 16'h0000, "standby");
    standby = 1'b0;
    wait_stable(STAB + 1);
    check_vec({10'h000, tmr_oe_o}, {10'h000, t_oe}, "after standby");
    // clock fault outside standby, sticky until reset
    run = 1'b0;
    repeat (15) @(negedge sys_clk_i);
    check_vec({15'h0000, clk_halt_o}, 16'h0000, "early halt");
    repeat (15) @(negedge sys_clk_i);
    check_vec({8'h00, clk_halt_o, op_undefined_o, tmr_oe_o}, 16'h00C0, "halt");
    run = 1'b1;
    repeat (30) @(negedge sys_clk_i);
    check_vec({9'h000, op_undefined_o, tmr_oe_o}, 16'h0040, "after restart");
    do_reset(7'h13, 7'h13);
    @(negedge sys_clk_i);
    check_vec({15'h0000, op_undefined_o}, 16'h0000, "fault cleared");
    complete_run();
  end
endmodule : tb
